// [hw/docs_consts.svh]
// register offsets, field positions and reset values of the output config
`ifndef DOCS_CONSTS_SVH
`define DOCS_CONSTS_SVH
`define DOCS_OFF_CTRL 12'h000
`define DOCS_OFF_STAT 12'h004
`define DOCS_BIT_CUR_ON 0
`define DOCS_BIT_VOLT_ON 1
`define DOCS_BIT_RANGE_SRC 2
`define DOCS_BIT_OFFSET_RANGE 3
`define DOCS_BIT_UNIPOLAR 4
`define DOCS_CTRL_RESET 5'h00
`define DOCS_CTRL_W 5
`define DOCS_BIT_ST_CUR 0
`define DOCS_BIT_ST_VOLT 1
`define DOCS_BIT_ST_R420 2
`define DOCS_BIT_ST_UNI 3
`define DOCS_BIT_ST_SW 4
`define DOCS_BIT_ST_STRAP 5
`endif

// [hw/docs_pkg.sv]
// types of the output configuration block
package docs_pkg;
   typedef enum logic [3:0] {
      DOCS_OFF = 4'h1,
      DOCS_CUR = 4'h2,
      DOCS_VOLT = 4'h4,
      DOCS_SW = 4'h8
   } docs_mode_e;
endpackage

// [hw/docs_decode.sv]
// combinational decode of straps and control bits into output settings
`timescale 1ns/1ps
module docs_decode (
   input wire logic cfgStrapHigh,
   input wire logic cfgStrapLow,
   input wire logic currentRangePin,
   input wire logic voltageDriveEnable,
   input wire logic currentDriveEnable,
   input wire logic rangeSourceSelect,
   input wire logic offsetRangeBit,
   output docs_pkg::docs_mode_e mode,
   output logic currentOn,
   output logic voltageOn,
   output logic range4to20
);
   always_comb begin
      case ({cfgStrapHigh, cfgStrapLow})
         2'h0: mode = docs_pkg::DOCS_OFF;
         2'h1: mode = docs_pkg::DOCS_CUR;
         2'h2: mode = docs_pkg::DOCS_VOLT;
         default: mode = docs_pkg::DOCS_SW;
      endcase
   end

   // straps win; software bits only matter in mode 11
   always_comb begin
      currentOn = 1'b0;
      voltageOn = 1'b0;
      case (mode)
         docs_pkg::DOCS_OFF: begin
            currentOn = 1'b0;
         end
         docs_pkg::DOCS_CUR: currentOn = 1'b1;
         docs_pkg::DOCS_VOLT: voltageOn = 1'b1;
         docs_pkg::DOCS_SW: begin
            // both set is treated as both off
            currentOn = currentDriveEnable & ~voltageDriveEnable;
            voltageOn = voltageDriveEnable & ~currentDriveEnable;
         end
         default: begin
            currentOn = 1'b0;
         end
      endcase
   end

   always_comb begin
      if (rangeSourceSelect) begin
         range4to20 = offsetRangeBit;
      end else begin
         range4to20 = currentRangePin;
      end
   end
endmodule

// [hw/docs_top.sv]
// output configuration select: straps, apb control register, outputs
// Contract
// - straps 00 disable both outputs
// - straps 01 enable current output only
// - straps 10 enable voltage output only
// - straps 11 give control to software
// - software pair decode, 11 means off
// - enable bits reset to zero
// - range source 0: pin picks range
// - range source 1: software bit picks range
// - polarity bit 0 bipolar, 1 unipolar
// - straps override software commands
`timescale 1ns/1ps
`include "docs_consts.svh"
module docs_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cfgStrapHigh,
   input wire logic cfgStrapLow,
   input wire logic currentRangePin,
   output logic currentOutputEn,
   output logic voltageOutputEn,
   output logic currentRange4to20,
   output logic voltageUnipolar
);
   logic [`DOCS_CTRL_W-1:0] ctrl_reg;
   logic [`DOCS_CTRL_W-1:0] ctrl_next;
   docs_pkg::docs_mode_e mode;
   logic curOn;
   logic voltOn;
   logic r420;
   logic setup;
   logic hit;
   logic [31:0] rd_next;

   assign setup = psel & ~penable;
   assign hit = (paddr == `DOCS_OFF_CTRL) || (paddr == `DOCS_OFF_STAT);

   always_comb begin
      ctrl_next = ctrl_reg;
      // land only at the edge the master sees ready
      if (psel && penable && pready && pwrite && paddr == `DOCS_OFF_CTRL) begin
         ctrl_next = pwdata[`DOCS_CTRL_W-1:0];
      end
   end

   // enables come up cleared
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_reg <= `DOCS_CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   docs_decode u_dec (
      .cfgStrapHigh(cfgStrapHigh),
      .cfgStrapLow(cfgStrapLow),
      .currentRangePin(currentRangePin),
      .voltageDriveEnable(ctrl_next[`DOCS_BIT_VOLT_ON]),
      .currentDriveEnable(ctrl_next[`DOCS_BIT_CUR_ON]),
      .rangeSourceSelect(ctrl_next[`DOCS_BIT_RANGE_SRC]),
      .offsetRangeBit(ctrl_next[`DOCS_BIT_OFFSET_RANGE]),
      .mode(mode),
      .currentOn(curOn),
      .voltageOn(voltOn),
      .range4to20(r420)
   );

   // registered every cycle, one edge after any input change
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         currentOutputEn <= 1'b0;
         voltageOutputEn <= 1'b0;
         currentRange4to20 <= 1'b0;
         voltageUnipolar <= 1'b0;
      end else begin
         currentOutputEn <= curOn;
         voltageOutputEn <= voltOn;
         currentRange4to20 <= r420;
         voltageUnipolar <= ctrl_next[`DOCS_BIT_UNIPOLAR];
      end
   end

   // zero-wait slave: answers in the first access cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~hit;
         prdata <= setup ? rd_next : 32'h0000_0000;
      end
   end

   always_comb begin
      rd_next = 32'h0000_0000;
      if (paddr == `DOCS_OFF_CTRL) begin
         rd_next[`DOCS_CTRL_W-1:0] = ctrl_reg;
      end else if (paddr == `DOCS_OFF_STAT) begin
         rd_next[`DOCS_BIT_ST_CUR] = currentOutputEn;
         rd_next[`DOCS_BIT_ST_VOLT] = voltageOutputEn;
         rd_next[`DOCS_BIT_ST_R420] = currentRange4to20;
         rd_next[`DOCS_BIT_ST_UNI] = voltageUnipolar;
         rd_next[`DOCS_BIT_ST_SW] = (mode == docs_pkg::DOCS_SW);
         rd_next[`DOCS_BIT_ST_STRAP+1:`DOCS_BIT_ST_STRAP] =
            {cfgStrapHigh, cfgStrapLow};
      end
   end

   // strap decode and software hand-over
   a_strap_off: assert property (
      @(posedge clk_sys) disable iff (rst)
      !cfgStrapHigh && !cfgStrapLow |=> !currentOutputEn && !voltageOutputEn)
      else $error("outputs not off for straps 00");
   a_strap_cur: assert property (
      @(posedge clk_sys) disable iff (rst)
      !cfgStrapHigh && cfgStrapLow |=> currentOutputEn && !voltageOutputEn)
      else $error("current not sole output for straps 01");
   a_strap_volt: assert property (
      @(posedge clk_sys) disable iff (rst)
      cfgStrapHigh && !cfgStrapLow |=> voltageOutputEn && !currentOutputEn)
      else $error("voltage not sole output for straps 10");
   a_sw_follow: assert property (
      @(posedge clk_sys) disable iff (rst)
      cfgStrapHigh && cfgStrapLow |=>
      currentOutputEn == $past(ctrl_next[`DOCS_BIT_CUR_ON] &
         ~ctrl_next[`DOCS_BIT_VOLT_ON]))
      else $error("software current enable not followed");
   a_sw_volt: assert property (
      @(posedge clk_sys) disable iff (rst)
      cfgStrapHigh && cfgStrapLow |=>
      voltageOutputEn == $past(ctrl_next[`DOCS_BIT_VOLT_ON] &
         ~ctrl_next[`DOCS_BIT_CUR_ON]))
      else $error("software voltage enable not followed");
   a_sw_both: assert property (
      @(posedge clk_sys) disable iff (rst)
      cfgStrapHigh && cfgStrapLow && ctrl_next[`DOCS_BIT_CUR_ON] &&
      ctrl_next[`DOCS_BIT_VOLT_ON] |=> !currentOutputEn && !voltageOutputEn)
      else $error("software 11 did not power down");
   a_sw_none: assert property (
      @(posedge clk_sys) disable iff (rst)
      cfgStrapHigh && cfgStrapLow && !ctrl_next[`DOCS_BIT_CUR_ON] &&
      !ctrl_next[`DOCS_BIT_VOLT_ON] |=> !currentOutputEn && !voltageOutputEn)
      else $error("software 00 did not power down");
   a_hw_wins: assert property (
      @(posedge clk_sys) disable iff (rst)
      !(cfgStrapHigh && cfgStrapLow) && ctrl_next[`DOCS_BIT_CUR_ON] |=>
      currentOutputEn == $past(cfgStrapLow && !cfgStrapHigh))
      else $error("software enable overrode the straps");
   a_never_both: assert property (
      @(posedge clk_sys) disable iff (rst)
      !(currentOutputEn && voltageOutputEn))
      else $error("both outputs enabled");
   // reset defaults, checked at the first edge after release
   a_reset_clear: assert property (
      @(posedge clk_sys)
      $fell(rst) |-> ctrl_reg[1:0] == 2'h0)
      else $error("enable bits not cleared by reset");
   a_reset_outs: assert property (
      @(posedge clk_sys)
      $fell(rst) |-> !currentOutputEn && !voltageOutputEn)
      else $error("outputs not off after reset");
   a_reset_source: assert property (
      @(posedge clk_sys)
      $fell(rst) |-> !ctrl_reg[`DOCS_BIT_RANGE_SRC])
      else $error("range source not pin after reset");
   a_reset_polar: assert property (
      @(posedge clk_sys)
      $fell(rst) |-> !ctrl_reg[`DOCS_BIT_UNIPOLAR] && !voltageUnipolar)
      else $error("voltage range not bipolar after reset");
   // range, polarity and strap change
   a_range_pin: assert property (
      @(posedge clk_sys) disable iff (rst)
      !ctrl_next[`DOCS_BIT_RANGE_SRC] |=>
      currentRange4to20 == $past(currentRangePin))
      else $error("range pin not followed");
   a_range_sw: assert property (
      @(posedge clk_sys) disable iff (rst)
      ctrl_next[`DOCS_BIT_RANGE_SRC] |=>
      currentRange4to20 == $past(ctrl_next[`DOCS_BIT_OFFSET_RANGE]))
      else $error("software range bit not followed");
   a_pin_change: assert property (
      @(posedge clk_sys) disable iff (rst)
      $changed(currentRangePin) && !ctrl_next[`DOCS_BIT_RANGE_SRC] |=>
      currentRange4to20 == $past(currentRangePin))
      else $error("range pin change not applied next cycle");
   a_polarity: assert property (
      @(posedge clk_sys) disable iff (rst)
      ##1 voltageUnipolar == $past(ctrl_next[`DOCS_BIT_UNIPOLAR]))
      else $error("polarity not followed");
   a_change_seen: assert property (
      @(posedge clk_sys) disable iff (rst)
      $changed(cfgStrapLow) && !cfgStrapHigh |=>
      currentOutputEn == $past(cfgStrapLow))
      else $error("strap change not applied next cycle");
   // first edge after reset still shows reset values, hence the past guard
   a_hold_steady: assert property (
      @(posedge clk_sys) disable iff (rst)
      !$past(rst) && $stable({cfgStrapHigh, cfgStrapLow, currentRangePin,
         ctrl_next}) |=> $stable({currentOutputEn, voltageOutputEn,
         currentRange4to20, voltageUnipolar}))
      else $error("outputs moved with steady inputs");
   // bus side
   a_ready_pulse: assert property (@(posedge clk_sys) disable iff (rst)
      pready |=> !pready)
      else $error("ready held for more than one cycle");
   a_bad_write: assert property (@(posedge clk_sys) disable iff (rst)
      psel && penable && pready && pwrite && paddr != `DOCS_OFF_CTRL |=>
      ctrl_reg == $past(ctrl_reg))
      else $error("write outside the control word changed it");
   a_write_lands: assert property (
      @(posedge clk_sys) disable iff (rst)
      psel && penable && pready && pwrite && paddr == `DOCS_OFF_CTRL |=>
      ctrl_reg == $past(pwdata[`DOCS_CTRL_W-1:0]))
      else $error("control write did not land");
endmodule

// [bench/docs_board.sv]
// board strap and range pin model
`timescale 1ns/1ps
module docs_board (
   input wire logic [1:0] strapSet,
   input wire logic pinSet,
   input wire logic pinTie,
   output logic cfgStrapHigh,
   output logic cfgStrapLow,
   output logic currentRangePin
);
   assign cfgStrapHigh = strapSet[1];
   assign cfgStrapLow = strapSet[0];
   // software range chosen: pin held at analog ground
   assign currentRangePin = pinTie ? 1'b0 : pinSet;
endmodule

// [bench/docs_top_bench.sv]
// self-checking bench of the output configuration select
`timescale 1ns/1ps
`define CHK(n,e,g) begin num_checks++; if ((g)!==(e)) begin failures++; \
$display("mismatch %s exp %h got %h", n, e, g); end end
module docs_top_bench;
   logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, hi, lo, pin, ce, ve, rg, un, cExp, vExp;
   logic [1:0] strap = 2'h0;
   logic pinSet = 0, pinTie = 0;
   int failures = 0, num_checks = 0;
   docs_board board (.strapSet(strap), .pinSet(pinSet), .pinTie(pinTie),
      .cfgStrapHigh(hi), .cfgStrapLow(lo), .currentRangePin(pin));
   docs_top uut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cfgStrapHigh(hi), .cfgStrapLow(lo), .currentRangePin(pin),
      .currentOutputEn(ce), .voltageOutputEn(ve),
      .currentRange4to20(rg), .voltageUnipolar(un));
   initial forever #10 clk_sys = ~clk_sys;
   // starts on a fresh edge so back-to-back calls never drive psel twice
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_sys);
      failures++;
      test_done();
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctrl", 32'h0, rd)
      `CHK("outs", 4'h0, {ce, ve, rg, un})
      for (int s = 0; s < 4; s++) begin
         for (int v = 0; v < 4; v++) begin
            apb(1'b1, 12'h000, v);
            strap <= s[1:0];
            cExp = s == 1 || (s == 3 && v == 1);
            vExp = s == 2 || (s == 3 && v == 2);
            repeat (2) @(posedge clk_sys);
            #1;
            `CHK("cur", cExp, ce)
            `CHK("volt", vExp, ve)
            apb(1'b0, 12'h004, 32'h0);
            `CHK("stat", {s[1:0], s == 3, vExp, cExp}, {rd[6:4], rd[1:0]})
         end
      end
      for (int r = 0; r < 8; r++) begin
         pinSet <= r[0];
         pinTie <= r == 7;
         apb(1'b1, 12'h000, {27'h0, r[0] ^ r[1], r[1], r[2], 2'b00});
         @(posedge clk_sys);
         #1;
         `CHK("range", r[2] ? r[1] : r[0], rg)
         `CHK("uni", r[0] ^ r[1], un)
      end
      apb(1'b1, 12'h008, 32'hFFFFFFFF);
      `CHK("werr", 1'b1, err)
      apb(1'b0, 12'h008, 32'h0);
      `CHK("rerr", {1'b1, 32'h0}, {err, rd})
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      `CHK("serr", 1'b0, err)
      apb(1'b0, 12'h000, 32'h0);
      `CHK("keep", 32'h0000000C, rd)
      // mid-run reset must drop the software settings again
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      apb(1'b0, 12'h000, 32'h0);
      `CHK("rst ctrl", 32'h0, rd)
      `CHK("rst outs", 4'h0, {ce, ve, rg, un})
      test_done();
   end
endmodule
